// [src/detect_regs.svh]
// Register offsets, field positions and reset values of the detector.
// Assumes an 8-bit register bus with a 4-bit word address.
`ifndef DETECT_REGS_SVH
`define DETECT_REGS_SVH

// Register offsets
`define ADDR_CTRL        4'h0
`define ADDR_IRQ_STATUS  4'h1
`define ADDR_IRQ_MASK    4'h2
`define ADDR_RESET_SRC   4'h3

// Detection control register fields
`define CTRL_EN_BIT      7
`define CTRL_SRC_BIT     2
`define CTRL_MODE_BIT    1
`define CTRL_FLAG_BIT    0

// Interrupt status and mask fields
`define IRQ_CROSS_BIT    0
`define IRQ_LVRST_BIT    1

// Reset source register fields
`define RSRC_LV_BIT      0
`define RSRC_WDT_BIT     4

// Reset values
`define CTRL_RESET       8'h00
`define IRQ_STATUS_RESET 8'h00
`define IRQ_MASK_RESET   8'h03
`define RSRC_RESET       8'h00

// Software settling wait after enabling, 10 us at 100 MHz
`define STAB_WAIT_CYCLES 1000

`endif

// [src/detect_pkg.sv]
// Types shared by the low-voltage detector control logic.
// Assumes 8-bit register data; the control struct here keeps only its three writable bits.
package detect_pkg;

	// One register bus request, all fields valid in the same cycle
	typedef struct packed {
		logic [3:0] addr;  // Register word address
		logic [7:0] wdata; // Write data
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
	} reg_bus_t;

	// Writable fields of the detection control register
	typedef struct packed {
		logic detector_enable_bit;       // Detector running
		logic level_source_select;       // 0 supply, 1 external pin
		logic reset_or_interrupt_select; // 0 interrupt, 1 reset
	} ctrl_t;

	// Level source choice
	typedef enum logic {
		SRC_SUPPLY   = 1'b0,
		SRC_EXTERNAL = 1'b1
	} level_source_t;

endpackage

// [src/level_sync_edge.sv]
// Two-stage synchroniser with edge detection for the comparator result.
// Assumes level_in may change at any time relative to clock.
`timescale 1ns/10ps

module level_sync_edge (
	input  wire logic clock,      // System clock
	input  wire logic sys_rst,    // Synchronous reset, active high
	input  wire logic level_in,   // Raw comparator level
	output logic      level_sync, // Level after synchronisation
	output logic      rise_pulse, // One cycle on a rising edge
	output logic      fall_pulse  // One cycle on a falling edge
);

	logic stage1_reg;
	logic stage2_reg;
	logic prev_reg;

	// Only stage2 looks at stage1, to let metastability settle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			prev_reg   <= 1'b0;
		end else begin
			stage1_reg <= level_in;
			stage2_reg <= stage1_reg;
			prev_reg   <= stage2_reg;
		end
	end

	// Edges compare two settled samples, so each crossing gives one pulse
	assign level_sync = stage2_reg;
	assign rise_pulse = stage2_reg & ~prev_reg;
	assign fall_pulse = ~stage2_reg & prev_reg;

endmodule

// [src/low_voltage_detect_control.sv]
// Control logic of the low-voltage detector: control register, source
// select, reset or interrupt reporting, reset cause and interrupt flags.
// Assumes the analog comparators deliver a level that is 1 while the
// watched voltage is under its detection level, and that sys_rst stands
// for the external and power-on reset, not for the reset made here.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "detect_regs.svh"

module low_voltage_detect_control (
	input  wire logic              clock,                 // 100 MHz clock
	input  wire logic              sys_rst,               // Sync reset
	input  wire detect_pkg::reg_bus_t bus,                // Register bus
	output logic [7:0]             rd_data,               // Read data
	input  wire logic              supply_below,          // Supply low
	input  wire logic              external_below,        // Pin low
	input  wire logic              watchdog_reset_event,  // Dog reset
	output logic                   low_voltage_interrupt, // Level irq
	output logic                   internal_reset_req     // Reset out
);

	detect_pkg::ctrl_t ctrl_reg;
	logic [7:0]        irq_status_reg;
	logic [7:0]        irq_status_next;
	logic [7:0]        irq_mask_reg;
	logic [7:0]        reset_src_reg;
	logic [7:0]        reset_src_next;
	logic [7:0]        rd_data_reg;
	logic              irq_reg;
	logic              lv_rst_reg;
	logic              lv_rst_next;
	logic              sel_level;
	logic              level_below;
	logic              rise_evt;
	logic              fall_evt;
	logic              cross_evt;
	logic              flag_now;

	// True when a strobe targets the given offset
	function automatic logic reg_hit(input logic [3:0] a,
		input logic [3:0] ofs, input logic strobe);
		reg_hit = strobe && (a == ofs);
	endfunction

	// Unpack a control byte into its writable fields
	function automatic detect_pkg::ctrl_t ctrl_from_byte(
		input logic [7:0] b);
		detect_pkg::ctrl_t c;
		c.detector_enable_bit       = b[`CTRL_EN_BIT];
		c.level_source_select       = b[`CTRL_SRC_BIT];
		c.reset_or_interrupt_select = b[`CTRL_MODE_BIT];
		ctrl_from_byte = c;
	endfunction

	// Pack the control fields and the live flag back into a byte
	function automatic logic [7:0] ctrl_to_byte(
		input detect_pkg::ctrl_t c, input logic flag);
		logic [7:0] b;
		b = 8'h00;
		b[`CTRL_EN_BIT]   = c.detector_enable_bit;
		b[`CTRL_SRC_BIT]  = c.level_source_select;
		b[`CTRL_MODE_BIT] = c.reset_or_interrupt_select;
		b[`CTRL_FLAG_BIT] = flag;
		ctrl_to_byte = b;
	endfunction

	// Source select ahead of the synchroniser; a switch may look like a
	// crossing, which is why software must mask the interrupt while switching
	assign sel_level = (ctrl_reg.level_source_select ==
		detect_pkg::SRC_EXTERNAL) ? external_below : supply_below;

	// Comparator result into the clock domain
	level_sync_edge u_sync (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.level_in   (sel_level),
		.level_sync (level_below),
		.rise_pulse (rise_evt),
		.fall_pulse (fall_evt)
	);

	// Flag only means something while the detector runs
	assign flag_now = ctrl_reg.detector_enable_bit & level_below;

	// Crossings count as interrupt events only in interrupt mode
	assign cross_evt = ctrl_reg.detector_enable_bit &
		~ctrl_reg.reset_or_interrupt_select &
		(rise_evt | fall_evt);

	// Reset request follows the synchronised level, no latching
	assign lv_rst_next = ctrl_reg.detector_enable_bit &
		ctrl_reg.reset_or_interrupt_select & level_below;

	// Control register; bit 0 is read only and never stored
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_reg <= ctrl_from_byte(`CTRL_RESET);
		end else if (reg_hit(bus.addr, `ADDR_CTRL, bus.wr)) begin
			ctrl_reg <= ctrl_from_byte(bus.wdata);
		end
	end

	// Interrupt mask register, bit 0 is the detector interrupt mask
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_mask_reg <= `IRQ_MASK_RESET;
		end else if (reg_hit(bus.addr, `ADDR_IRQ_MASK, bus.wr)) begin
			irq_mask_reg <= bus.wdata;
		end
	end

	// Sticky status; a new event in the clearing read wins over the clear
	always_comb begin
		irq_status_next = irq_status_reg;
		if (reg_hit(bus.addr, `ADDR_IRQ_STATUS, bus.rd)) begin
			irq_status_next = 8'h00;
		end
		if (cross_evt) begin
			irq_status_next[`IRQ_CROSS_BIT] = 1'b1;
		end
		if (lv_rst_next && !lv_rst_reg) begin
			irq_status_next[`IRQ_LVRST_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_status_reg <= `IRQ_STATUS_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	// Reset cause flags; a read clears them, a new cause still lands
	always_comb begin
		reset_src_next = reset_src_reg;
		if (reg_hit(bus.addr, `ADDR_RESET_SRC, bus.rd)) begin
			reset_src_next = 8'h00;
		end
		if (watchdog_reset_event) begin
			reset_src_next[`RSRC_WDT_BIT] = 1'b1;
		end
		if (lv_rst_reg) begin
			reset_src_next[`RSRC_LV_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reset_src_reg <= `RSRC_RESET;
		end else begin
			reset_src_reg <= reset_src_next;
		end
	end

	// Internal reset output straight from a flop
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lv_rst_reg <= 1'b0;
		end else begin
			lv_rst_reg <= lv_rst_next;
		end
	end

	// Interrupt line tracks the next status so it rises with the flag
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_status_next & ~irq_mask_reg);
		end
	end

	// Read data stands for the single cycle after the read strobe
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_data_reg <= 8'h00;
		end else if (!bus.rd) begin
			rd_data_reg <= 8'h00;
		end else if (bus.addr == `ADDR_CTRL) begin
			rd_data_reg <= ctrl_to_byte(ctrl_reg, flag_now);
		end else if (bus.addr == `ADDR_IRQ_STATUS) begin
			rd_data_reg <= irq_status_reg;
		end else if (bus.addr == `ADDR_IRQ_MASK) begin
			rd_data_reg <= irq_mask_reg;
		end else if (bus.addr == `ADDR_RESET_SRC) begin
			rd_data_reg <= reset_src_reg;
		end else begin
			rd_data_reg <= 8'h00;
		end
	end

	assign rd_data               = rd_data_reg;
	assign low_voltage_interrupt = irq_reg;
	assign internal_reset_req    = lv_rst_reg;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Selected input held for the synchroniser depth
	sequence ext_low_held;
		(ctrl_reg.level_source_select && external_below)[*3];
	endsequence

	sequence supply_high_held;
		(!ctrl_reg.level_source_select && !supply_below)[*3];
	endsequence

	// A control write followed by one settling cycle
	sequence ctrl_written;
		reg_hit(bus.addr, `ADDR_CTRL, bus.wr) ##1 1'b1;
	endsequence

	// Reporting in reset and in interrupt mode
	a_reset_while_low:
	assert property (lv_rst_next |=> internal_reset_req)
		else $error("internal reset missing while level low");

	a_reset_released:
	assert property (ctrl_reg.detector_enable_bit && !level_below
		|=> !internal_reset_req)
		else $error("internal reset held with level high");

	a_crossing_sets_irq:
	assert property (ctrl_reg.detector_enable_bit &&
		!ctrl_reg.reset_or_interrupt_select && (rise_evt || fall_evt)
		|=> irq_status_reg[`IRQ_CROSS_BIT])
		else $error("crossing did not set request flag");

	a_irq_mode_no_reset:
	assert property (!ctrl_reg.reset_or_interrupt_select
		|=> !internal_reset_req)
		else $error("reset raised in interrupt mode");

	a_ext_source_used:
	assert property (ext_low_held |-> level_below)
		else $error("external level not followed");

	a_supply_source_used:
	assert property (supply_high_held |-> !level_below)
		else $error("supply level not followed");

	// Control register fields, enable and flag
	a_flag_readback:
	assert property (reg_hit(bus.addr, `ADDR_CTRL, bus.rd)
		|=> rd_data[`CTRL_FLAG_BIT] == $past(flag_now))
		else $error("comparison flag read wrong");

	a_ctrl_fields:
	assert property (reg_hit(bus.addr, `ADDR_CTRL, bus.wr) |=>
		ctrl_reg.reset_or_interrupt_select ==
		$past(bus.wdata[`CTRL_MODE_BIT]) &&
		ctrl_reg.level_source_select ==
		$past(bus.wdata[`CTRL_SRC_BIT]))
		else $error("mode or source field not stored");

	a_enable_write:
	assert property (ctrl_written |->
		ctrl_reg.detector_enable_bit == $past(bus.wdata[`CTRL_EN_BIT]))
		else $error("enable bit not stored");

	a_disabled_quiet:
	assert property (!ctrl_reg.detector_enable_bit &&
		!irq_status_reg[`IRQ_CROSS_BIT]
		|=> !internal_reset_req && !irq_status_reg[`IRQ_CROSS_BIT])
		else $error("disabled detector still active");

	a_mode_default:
	assert property ($fell(sys_rst) |->
		!ctrl_reg.reset_or_interrupt_select &&
		!ctrl_reg.detector_enable_bit)
		else $error("mode select not zero after reset");

	a_cause_flag_set:
	assert property (internal_reset_req
		|=> reset_src_reg[`RSRC_LV_BIT])
		else $error("low-voltage cause flag not set");

	a_watchdog_held:
	assert property (internal_reset_req && !watchdog_reset_event &&
		!reg_hit(bus.addr, `ADDR_RESET_SRC, bus.rd)
		|=> $stable(reset_src_reg[`RSRC_WDT_BIT]))
		else $error("watchdog cause flag changed");

	// A level change on both sides in two cycles is two crossings,
	// so each edge kind is checked on its own
	a_single_edge:
	assert property (rise_evt |=> !rise_evt)
		else $error("crossing gave more than one event");

	a_single_fall:
	assert property (fall_evt |=> !fall_evt)
		else $error("falling crossing gave two events");

	// Register bus, sticky status and reset cause behaviour
	a_irq_level:
	assert property (!reg_hit(bus.addr, `ADDR_IRQ_MASK, bus.wr) |=>
		low_voltage_interrupt == |(irq_status_reg & ~irq_mask_reg))
		else $error("interrupt line does not follow status");

	a_status_clear:
	assert property (reg_hit(bus.addr, `ADDR_IRQ_STATUS, bus.rd) &&
		!cross_evt && !(lv_rst_next && !lv_rst_reg)
		|=> irq_status_reg == 8'h00)
		else $error("status not cleared by read");

	a_read_idle_zero:
	assert property (!bus.rd |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");

	a_cause_clear:
	assert property (reg_hit(bus.addr, `ADDR_RESET_SRC, bus.rd) &&
		!watchdog_reset_event && !internal_reset_req
		|=> reset_src_reg == 8'h00)
		else $error("reset cause not cleared by read");

	a_reset_needs_mode:
	assert property (internal_reset_req |->
		$past(ctrl_reg.reset_or_interrupt_select &&
		ctrl_reg.detector_enable_bit))
		else $error("internal reset outside enabled reset mode");

	a_ctrl_readback:
	assert property (reg_hit(bus.addr, `ADDR_CTRL, bus.rd) |=>
		rd_data[`CTRL_EN_BIT] == $past(ctrl_reg.detector_enable_bit) &&
		rd_data[`CTRL_SRC_BIT] == $past(ctrl_reg.level_source_select) &&
		rd_data[`CTRL_MODE_BIT] ==
		$past(ctrl_reg.reset_or_interrupt_select))
		else $error("control fields read wrong");

	a_flag_off_disabled:
	assert property (reg_hit(bus.addr, `ADDR_CTRL, bus.rd) &&
		!ctrl_reg.detector_enable_bit |=> !rd_data[`CTRL_FLAG_BIT])
		else $error("flag set while detector stopped");

endmodule

// [sim/comparator_model.sv]
// Stand-in for the analog comparators that sit in front of the block.
// Assumes the bench changes the commanded levels just after a rising edge.
`timescale 1ns/10ps

module comparator_model (
	input  wire logic clock,              // System clock
	input  wire logic supply_cmd,         // Supply under level when 1
	input  wire logic external_cmd,       // Pin under reference when 1
	output logic      supply_below = 1'b0,  // Supply comparator
	output logic      external_below = 1'b0 // Pin comparator
);
	// One cycle of delay, since a real comparator never answers at once
	always @(posedge clock) begin
		supply_below <= supply_cmd;
		external_below <= external_cmd;
	end
endmodule

// [sim/low_voltage_detect_control_tb.sv]
// Self-checking bench for the detector control block.
// Assumes the register map and reset values of the shared header.
`timescale 1ns/10ps
`include "detect_regs.svh"

module low_voltage_detect_control_tb;
	logic                 clock = 1'b0;
	logic                 sys_rst = 1'b1;
	detect_pkg::reg_bus_t bus = '0;
	logic [7:0]           rd_data;
	logic                 supply_cmd = 1'b0;
	logic                 external_cmd = 1'b0;
	logic                 supply_below;
	logic                 external_below;
	logic                 watchdog_reset_event = 1'b0;
	logic                 low_voltage_interrupt;
	logic                 internal_reset_req;
	int                   miscompares = 0;
	int                   cmp_count = 0;
	int                   seed = 10464;
	int                   ctrl_m = 0;
	int                   v;
	logic [7:0]           got;

	always #5 clock = ~clock;

	low_voltage_detect_control dut (
		.clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
		.supply_below(supply_below), .external_below(external_below),
		.watchdog_reset_event(watchdog_reset_event),
		.low_voltage_interrupt(low_voltage_interrupt),
		.internal_reset_req(internal_reset_req));

	comparator_model far (
		.clock(clock), .supply_cmd(supply_cmd),
		.external_cmd(external_cmd), .supply_below(supply_below),
		.external_below(external_below));

	// Mismatch report and counting
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Single-cycle write; the model keeps only writable control bits
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
		if (a == `ADDR_CTRL)
			ctrl_m = d & 8'h86;
	endtask

	// Read strobe, data taken in the one cycle it stands
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(d, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the little over a thousand cycles needed
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset values and an unmapped place
		rdc(`ADDR_CTRL, `CTRL_RESET);
		rdc(`ADDR_IRQ_STATUS, 8'h00);
		rdc(`ADDR_IRQ_MASK, 8'h03);
		rdc(`ADDR_RESET_SRC, 8'h00);
		rdc(4'h7, 8'h00);
		// Pin source start: mask stays set, select, enable, settle, clear
		wr(`ADDR_CTRL, 8'h04);
		wr(`ADDR_CTRL, 8'h84);
		idle(`STAB_WAIT_CYCLES);
		rdc(`ADDR_CTRL, 8'h84);
		rd(`ADDR_IRQ_STATUS, got);
		wr(`ADDR_IRQ_MASK, 8'h00);
		// Falling level on the pin is one event, flag follows it
		external_cmd <= 1'b1;
		idle(6);
		check({7'h00, low_voltage_interrupt}, 8'h01);
		rdc(`ADDR_CTRL, 8'h85);
		rdc(`ADDR_IRQ_STATUS, 8'h01);
		rdc(`ADDR_IRQ_STATUS, 8'h00);
		check({7'h00, low_voltage_interrupt}, 8'h00);
		// Rising back also raises the request
		external_cmd <= 1'b0;
		idle(6);
		rdc(`ADDR_IRQ_STATUS, 8'h01);
		// Unselected supply comparator is ignored
		supply_cmd <= 1'b1;
		idle(6);
		rdc(`ADDR_IRQ_STATUS, 8'h00);
		rdc(`ADDR_CTRL, 8'h84);
		supply_cmd <= 1'b0;
		// Reset mode on the supply; earlier watchdog cause must survive
		wr(`ADDR_IRQ_MASK, 8'h03);
		wr(`ADDR_CTRL, 8'h82);
		idle(6);
		rd(`ADDR_IRQ_STATUS, got);
		@(posedge clock);
		watchdog_reset_event <= 1'b1;
		@(posedge clock);
		watchdog_reset_event <= 1'b0;
		supply_cmd <= 1'b1;
		idle(6);
		check({7'h00, internal_reset_req}, 8'h01);
		rdc(`ADDR_RESET_SRC, 8'h11);
		rdc(`ADDR_IRQ_STATUS, 8'h02);
		supply_cmd <= 1'b0;
		idle(6);
		check({7'h00, internal_reset_req}, 8'h00);
		// Interrupt mode on the supply: both crossings, no reset
		wr(`ADDR_CTRL, 8'h80);
		rd(`ADDR_IRQ_STATUS, got);
		wr(`ADDR_IRQ_MASK, 8'h02);
		supply_cmd <= 1'b1;
		idle(6);
		check({7'h00, low_voltage_interrupt}, 8'h01);
		check({7'h00, internal_reset_req}, 8'h00);
		rdc(`ADDR_IRQ_STATUS, 8'h01);
		supply_cmd <= 1'b0;
		idle(6);
		rdc(`ADDR_IRQ_STATUS, 8'h01);
		// Stop by a zero write; nothing is reported afterwards
		wr(`ADDR_CTRL, 8'h00);
		rdc(`ADDR_CTRL, 8'h00);
		external_cmd <= 1'b1;
		supply_cmd <= 1'b1;
		idle(6);
		check({7'h00, internal_reset_req}, 8'h00);
		rdc(`ADDR_CTRL, 8'h00);
		rd(`ADDR_IRQ_STATUS, got);
		check(got & 8'h01, 8'h00);
		// Random field values, enable kept low; random unmapped traffic
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			wr(`ADDR_CTRL, v[7:0] & 8'h7f);
			rdc(`ADDR_CTRL, ctrl_m[7:0]);
			wr(4'hc, v[15:8]);
			rdc(4'hc, 8'h00);
		end
		print_verdict();
	end
endmodule
